// ===== logic/cgt_pkg.sv
// constants, types and helpers shared by the guard-time uart block
package cgt_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_DIVIDER = 8'h02;
    localparam logic [7:0] IDX_CONFIG2 = 8'h03;
    localparam logic [7:0] IDX_GUARD = 8'h05;
    localparam logic [7:0] IDX_CONFIG1 = 8'h06;
    localparam logic [7:0] IDX_HOLDING = 8'h08;
    localparam logic [7:0] IDX_STATUS = 8'h09;
    localparam int unsigned ADDR_SHIFT = 2;
    // field positions
    localparam int unsigned PSC_BIT = 0;
    localparam int unsigned TXMODE_BIT = 3;
    localparam int unsigned PROTOCOL_SELECT_BIT = 4;
    localparam int unsigned ST_EMPTY_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 1;
    // reset values
    localparam logic [7:0] DIVIDER_RST = 8'h00;
    localparam logic [7:0] GUARD_RST = 8'h00;
    localparam logic [7:0] HOLDING_RST = 8'h00;
    // etu arithmetic, counted in fifths of an etu
    localparam int unsigned ETU_W = 13;
    localparam int unsigned FIFTH_W = 11;
    localparam logic [5:0] PRESCALE_LO = 6'h1f;
    localparam logic [5:0] PRESCALE_HI = 6'h20;
    localparam logic [2:0] FIFTHS_PER_ETU = 3'h5;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [7:0] GUARD_SPECIAL = 8'hff;
    localparam logic [3:0] STOP_T0 = 4'ha;
    localparam logic [3:0] STOP_T1 = 4'h5;
    localparam logic [3:0] REV2_TRIM = 4'h1;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CGT_IDLE = 2'h0,
        CGT_GUARD = 2'h1,
        CGT_BITS = 2'h2,
        CGT_STOP = 2'h3
    } cgt_tx_state_e;

    // fifths of an etu spent before the start bit
    function automatic logic [FIFTH_W-1:0] cgt_guard_fifths(input logic [7:0] gt);
        if (gt == GUARD_SPECIAL) begin
            return '0;
        end
        return FIFTH_W'({gt, 2'h0}) + FIFTH_W'(gt);
    endfunction

    // fifths of an etu the line idles after the parity bit
    function automatic logic [3:0] cgt_stop_fifths(input logic [7:0] gt, input logic protocol_select, input logic rev2);
        logic [3:0] base;
        base = protocol_select ? STOP_T1 : STOP_T0;
        if (gt == GUARD_SPECIAL && rev2) begin
            return base - REV2_TRIM;
        end
        return base;
    endfunction
endpackage

// ===== logic/cgt_link_if.sv
// link between the register front end, the etu timer and the frame sender
`timescale 1ns/100ps
`default_nettype none
interface cgt_link_if;
    import cgt_pkg::*;
    logic restart;
    logic fifth;
    logic [ETU_W-1:0] etu_len;
    logic start;
    logic [7:0] data;
    logic [7:0] guard;
    logic protocol_select;
    logic busy;
    logic io_out;
    logic io_oe;
    modport timer(input restart, input etu_len, output fifth);
    modport tx(input fifth, input start, input data, input guard, input protocol_select,
               output restart, output busy, output io_out, output io_oe);
    modport ctrl(output etu_len, output start, output data, output guard, output protocol_select,
                 input busy, input io_out, input io_oe);
endinterface
`default_nettype wire

// ===== logic/cgt_etu_timer.sv
// fractional etu timer: one tick per fifth of an etu, exact on average
`timescale 1ns/100ps
`default_nettype none
module cgt_etu_timer (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    cgt_link_if.timer lk
);
    import cgt_pkg::*;

    typedef struct packed {
        logic [ETU_W:0] acc;
        logic [2:0] fc;
        logic fifth;
        logic etu;
        logic [ETU_W-1:0] len;
    } cgt_tim_s;

    cgt_tim_s s_q;
    cgt_tim_s s_d;
    logic [ETU_W:0] h_cyc_q;

    // the restart reaches here a clock late and the sender acts a clock after a tick,
    // so a fresh etu starts two clocks along to keep the first bit exactly one etu
    localparam int unsigned LEAD_CLKS = 2;
    localparam logic [ETU_W:0] LEAD_CNT = (ETU_W + 1)'(LEAD_CLKS);
    localparam logic [ETU_W:0] LEAD_ACC = (ETU_W + 1)'(LEAD_CLKS * FIFTHS_PER_ETU);

    // a tick from the old phase must not reach the sender in its restart cycle
    assign lk.fifth = s_q.fifth && !lk.restart;

    // adding five per clock against the etu length avoids a divider
    always_comb begin
        logic [ETU_W:0] sum;
        sum = s_q.acc + (ETU_W + 1)'(FIFTHS_PER_ETU);
        s_d = s_q;
        s_d.fifth = 1'b0;
        s_d.etu = 1'b0;
        s_d.len = lk.etu_len;
        // a new etu length starts a fresh phase, like a restart
        if (lk.restart || lk.etu_len != s_q.len) begin
            s_d.acc = LEAD_ACC;
            s_d.fc = '0;
        end else if (lk.etu_len != '0) begin
            if (sum >= {1'b0, lk.etu_len}) begin
                s_d.acc = sum - {1'b0, lk.etu_len};
                s_d.fifth = 1'b1;
                if (s_q.fc == FIFTHS_PER_ETU - 3'h1) begin
                    s_d.fc = '0;
                    s_d.etu = 1'b1;
                end else begin
                    s_d.fc = s_q.fc + 3'h1;
                end
            end else begin
                s_d.acc = sum;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || lk.restart || lk.etu_len != s_q.len) begin
            h_cyc_q <= LEAD_CNT;
        end else if (s_q.etu) begin
            h_cyc_q <= (ETU_W + 1)'(1);
        end else begin
            h_cyc_q <= h_cyc_q + (ETU_W + 1)'(1);
        end
    end

    a_etu_length: assert property (@(posedge aclk) disable iff (!aresetn)
        s_q.etu |-> h_cyc_q == {1'b0, lk.etu_len})
        else $error("etu tick not one etu length apart");
endmodule
`default_nettype wire

// ===== logic/cgt_frame_tx.sv
// character sender: guard wait, start, eight data, parity, stop time
`timescale 1ns/100ps
`default_nettype none
module cgt_frame_tx #(
    parameter bit REV2 = 1'b0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // link
    cgt_link_if.tx lk
);
    import cgt_pkg::*;

    typedef struct packed {
        cgt_tx_state_e st;
        logic [FIFTH_W-1:0] cnt;
        logic [3:0] bit_idx;
        logic [9:0] shreg;
        logic [7:0] gt;
        logic protocol_select;
        logic restart;
        logic busy;
        logic io_out;
        logic io_oe;
    } cgt_tx_s;

    localparam cgt_tx_s TX_RST = '{st: CGT_IDLE, io_out: 1'b1, default: '0};

    cgt_tx_s s_q;
    cgt_tx_s s_d;
    logic [FIFTH_W-1:0] hg_q;
    logic [3:0] hs_q;

    assign lk.restart = s_q.restart;
    assign lk.busy = s_q.busy;
    assign lk.io_out = s_q.io_out;
    assign lk.io_oe = s_q.io_oe;

    always_comb begin
        s_d = s_q;
        s_d.restart = 1'b0;
        unique case (s_q.st)
            CGT_IDLE: begin
                if (lk.start) begin
                    // settings are frozen per character
                    s_d.gt = lk.guard;
                    s_d.protocol_select = lk.protocol_select;
                    s_d.shreg = {^lk.data, lk.data, 1'b0};
                    s_d.cnt = '0;
                    s_d.bit_idx = '0;
                    s_d.restart = 1'b1;
                    s_d.busy = 1'b1;
                    if (cgt_guard_fifths(lk.guard) == '0) begin
                        s_d.st = CGT_BITS;
                        s_d.io_oe = 1'b1;
                        s_d.io_out = 1'b0;
                    end else begin
                        s_d.st = CGT_GUARD;
                    end
                end
            end
            CGT_GUARD: begin
                if (lk.fifth) begin
                    s_d.cnt = s_q.cnt + FIFTH_W'(1);
                    if (s_d.cnt == cgt_guard_fifths(s_q.gt)) begin
                        s_d.st = CGT_BITS;
                        s_d.cnt = '0;
                        s_d.io_oe = 1'b1;
                        s_d.io_out = s_q.shreg[0];
                    end
                end
            end
            CGT_BITS: begin
                if (lk.fifth) begin
                    s_d.cnt = s_q.cnt + FIFTH_W'(1);
                    if (s_d.cnt == FIFTH_W'(FIFTHS_PER_ETU)) begin
                        s_d.cnt = '0;
                        if (s_q.bit_idx == FRAME_BITS - 4'h1) begin
                            s_d.st = CGT_STOP;
                            s_d.io_oe = 1'b0;
                            s_d.io_out = 1'b1;
                        end else begin
                            s_d.bit_idx = s_q.bit_idx + 4'h1;
                            s_d.shreg = {1'b1, s_q.shreg[9:1]};
                            s_d.io_out = s_q.shreg[1];
                        end
                    end
                end
            end
            CGT_STOP: begin
                if (lk.fifth) begin
                    s_d.cnt = s_q.cnt + FIFTH_W'(1);
                    if (s_d.cnt == FIFTH_W'(cgt_stop_fifths(s_q.gt, s_q.protocol_select, REV2))) begin
                        s_d.st = CGT_IDLE;
                        s_d.busy = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= TX_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // fifth ticks seen in the guard and stop phases, for checking only
    always_ff @(posedge aclk) begin
        if (!aresetn || s_q.st == CGT_IDLE) begin
            hg_q <= '0;
        end else if (s_q.st == CGT_GUARD && lk.fifth) begin
            hg_q <= hg_q + FIFTH_W'(1);
        end
        if (!aresetn || s_q.st == CGT_BITS) begin
            hs_q <= '0;
        end else if (s_q.st == CGT_STOP && lk.fifth) begin
            hs_q <= hs_q + 4'h1;
        end
    end

    a_guard_wait: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_q.st) == CGT_GUARD && s_q.st == CGT_BITS) |-> hg_q == FIFTH_W'({s_q.gt, 2'h0}) + FIFTH_W'(s_q.gt))
        else $error("guard wait not guard value times one etu");
    a_ff_block: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_q.st) == CGT_STOP && s_q.st == CGT_IDLE && s_q.protocol_select && s_q.gt == GUARD_SPECIAL)
        |-> hs_q == (REV2 ? 4'h4 : 4'h5))
        else $error("block protocol special guard period wrong");
    a_ff_char: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_q.st) == CGT_STOP && s_q.st == CGT_IDLE && !s_q.protocol_select && s_q.gt == GUARD_SPECIAL)
        |-> hs_q == (REV2 ? 4'h9 : 4'ha))
        else $error("character protocol special guard period wrong");
    a_protocol_select_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(s_q.st) == CGT_STOP && s_q.st == CGT_IDLE && s_q.gt != GUARD_SPECIAL)
        |-> hs_q == (s_q.protocol_select ? 4'h5 : 4'ha))
        else $error("stop time does not follow protocol select");
endmodule
`default_nettype wire

// ===== logic/cgt_uart_guard.sv
// guard-time character timing of a card uart, registers over axi4-lite
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module cgt_uart_guard #(
    parameter bit REV2 = 1'b0
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    // axi4-lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // axi4-lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // axi4-lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    // axi4-lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // card i/o line
    output logic io_out,
    output logic io_oe
);
    import cgt_pkg::*;

    localparam logic [7:0] ADDR_DIVIDER = IDX_DIVIDER << ADDR_SHIFT;
    localparam logic [7:0] ADDR_CONFIG2 = IDX_CONFIG2 << ADDR_SHIFT;
    localparam logic [7:0] ADDR_GUARD = IDX_GUARD << ADDR_SHIFT;
    localparam logic [7:0] ADDR_CONFIG1 = IDX_CONFIG1 << ADDR_SHIFT;
    localparam logic [7:0] ADDR_HOLDING = IDX_HOLDING << ADDR_SHIFT;
    localparam logic [7:0] ADDR_STATUS = IDX_STATUS << ADDR_SHIFT;

    typedef struct packed {
        logic [7:0] divider;
        logic prescaler_select;
        logic [7:0] guard;
        logic protocol_select;
        logic tx_mode;
        logic [7:0] holding;
        logic full;
        logic start;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [7:0] wdata;
        logic wstrb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cgt_regs_s;

    localparam cgt_regs_s REGS_RST = '{divider: DIVIDER_RST, guard: GUARD_RST,
                                       holding: HOLDING_RST, default: '0};

    cgt_regs_s s_q;
    cgt_regs_s s_d;

    cgt_link_if lk ();

    cgt_etu_timer u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk.timer)
    );

    cgt_frame_tx #(
        .REV2(REV2)
    ) u_tx (
        .aclk(aclk),
        .aresetn(aresetn),
        .lk(lk.tx)
    );

    // one etu in card clocks
    assign lk.etu_len = ETU_W'(s_q.prescaler_select ? PRESCALE_HI : PRESCALE_LO) * ETU_W'(s_q.divider);
    assign lk.start = s_q.start;
    assign lk.data = s_q.holding;
    assign lk.guard = s_q.guard;
    assign lk.protocol_select = s_q.protocol_select;

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;
    assign io_out = lk.io_out;
    assign io_oe = lk.io_oe;

    function automatic logic cgt_mapped(input logic [7:0] a);
        return a == ADDR_DIVIDER || a == ADDR_CONFIG2 || a == ADDR_GUARD ||
               a == ADDR_CONFIG1 || a == ADDR_HOLDING || a == ADDR_STATUS;
    endfunction

    function automatic logic [31:0] cgt_read(input cgt_regs_s r, input logic [7:0] a, input logic busy);
        logic [7:0] v;
        v = '0;
        unique case (a)
            ADDR_DIVIDER: v = r.divider;
            ADDR_CONFIG2: v[PSC_BIT] = r.prescaler_select;
            ADDR_GUARD: v = r.guard;
            ADDR_CONFIG1: begin
                v[PROTOCOL_SELECT_BIT] = r.protocol_select;
                v[TXMODE_BIT] = r.tx_mode;
            end
            ADDR_HOLDING: v = r.holding;
            ADDR_STATUS: begin
                v[ST_EMPTY_BIT] = !r.full;
                v[ST_BUSY_BIT] = busy;
            end
            default: v = '0;
        endcase
        return {24'h00_0000, v};
    endfunction

    always_comb begin
        s_d = s_q;
        // hand one character to the sender while idle in transmit mode
        s_d.start = s_q.full && s_q.tx_mode && !lk.busy && !s_q.start;
        if (s_q.start) begin
            s_d.full = 1'b0;
        end
        // write address and data are caught in either order
        if (awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = wdata[7:0];
            s_d.wstrb0 = wstrb[0];
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_have && s_q.w_have) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = cgt_mapped(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.wstrb0) begin
                unique case (s_q.awaddr)
                    ADDR_DIVIDER: s_d.divider = s_q.wdata;
                    ADDR_CONFIG2: s_d.prescaler_select = s_q.wdata[PSC_BIT];
                    ADDR_GUARD: s_d.guard = s_q.wdata;
                    ADDR_CONFIG1: begin
                        s_d.protocol_select = s_q.wdata[PROTOCOL_SELECT_BIT];
                        s_d.tx_mode = s_q.wdata[TXMODE_BIT];
                    end
                    ADDR_HOLDING: begin
                        // a new character beats the hand-off clear
                        s_d.holding = s_q.wdata;
                        s_d.full = 1'b1;
                    end
                    default: s_d.divider = s_q.divider;
                endcase
            end
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready = !s_d.w_have && !s_d.bvalid;
        // read answered on the edge the address is taken
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end
        if (arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata = cgt_read(s_q, araddr, lk.busy);
            s_d.rresp = cgt_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= REGS_RST;
        end else begin
            s_q <= s_d;
        end
    end

    a_guard_reset: assert property (@(posedge aclk)
        !aresetn |=> s_q.guard == GUARD_RST)
        else $error("guard register not zero after reset");
    a_prescale_pick: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_q.aw_have && s_q.w_have && s_q.wstrb0 && s_q.awaddr == ADDR_CONFIG2)
        |=> (lk.etu_len == (s_q.prescaler_select ? 13'h0020 : 13'h001f) * ETU_W'(s_q.divider))
        ##0 (s_q.prescaler_select == $past(s_q.wdata[PSC_BIT])))
        else $error("prescaler select not followed");
    a_tx_handoff: assert property (@(posedge aclk) disable iff (!aresetn)
        (s_q.full && s_q.tx_mode && !lk.busy && !s_q.start) |=> s_q.start ##1 lk.busy)
        else $error("pending character not handed to sender");
endmodule
`default_nettype wire

// ===== tb/cgt_card_model.sv
// card on the far end of the i/o line: decodes characters and times them
`timescale 1ns/100ps
`default_nettype none
module cgt_card_model (
    // clock
    input wire logic aclk,
    // card line
    input wire logic io_out,
    input wire logic io_oe,
    input wire logic [12:0] etu_clks,
    // decoded characters and timing
    output var logic [7:0] rx_byte,
    output var logic rx_par_ok,
    output var int rx_count,
    output var int start_prev,
    output var int start_last,
    output var int drive_len
);
    logic line;
    logic [8:0] sh;
    int cyc;
    int run;
    // released line floats up through the pull-up, never holds the last bit
    assign line = (io_oe === 1'b1) ? io_out : 1'b1;
    initial begin
        cyc = 0;
        run = 0;
        drive_len = 0;
        rx_count = 0;
        start_prev = 0;
        start_last = 0;
        rx_byte = 8'h00;
        rx_par_ok = 1'b0;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
    end
    // sampled mid-cycle so the sender's flops have settled
    always @(negedge aclk) begin
        if (io_oe === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                drive_len <= run;
            end
            run <= 0;
        end
    end
    initial begin
        forever begin
            @(negedge aclk);
            if (line === 1'b0) begin
                start_prev = start_last;
                start_last = cyc;
                repeat (etu_clks / 2) @(negedge aclk);
                for (int n = 0; n < 9; n++) begin
                    repeat (etu_clks) @(negedge aclk);
                    sh[n] = line;
                end
                rx_byte = sh[7:0];
                // even parity over data and parity bit
                rx_par_ok = (^sh === 1'b0);
                rx_count++;
                while (line !== 1'b1) @(negedge aclk);
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/cgt_uart_guard_test.sv
// self-checking bench for the guard-time card uart
`timescale 1ns/100ps
`default_nettype none
module cgt_uart_guard_test;
    import cgt_pkg::*;
    localparam bit REV2 = 1'b1;
    localparam logic [7:0] A_DIV = 8'(IDX_DIVIDER << ADDR_SHIFT);
    localparam logic [7:0] A_CFG2 = 8'(IDX_CONFIG2 << ADDR_SHIFT);
    localparam logic [7:0] A_GUARD = 8'(IDX_GUARD << ADDR_SHIFT);
    localparam logic [7:0] A_CFG1 = 8'(IDX_CONFIG1 << ADDR_SHIFT);
    localparam logic [7:0] A_HOLD = 8'(IDX_HOLDING << ADDR_SHIFT);
    localparam logic [7:0] A_STAT = 8'(IDX_STATUS << ADDR_SHIFT);
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, io_out, io_oe, rx_par_ok;
    logic [7:0] awaddr, araddr, rx_byte, g, gv;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    int mismatches, checks_done, rx_count, start_prev, start_last, drive_len;
    int etu, per, exp_per, t0;
    logic [7:0] sent[$];

    cgt_uart_guard #(.REV2(REV2)) cgt_uart_guard_i (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .io_out(io_out), .io_oe(io_oe));
    cgt_card_model cgt_card_model_i (.aclk(aclk), .io_out(io_out), .io_oe(io_oe), .etu_clks(13'(etu)),
        .rx_byte(rx_byte), .rx_par_ok(rx_par_ok), .rx_count(rx_count), .start_prev(start_prev),
        .start_last(start_last), .drive_len(drive_len));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic time_out();
        mismatches++;
        $display("ERROR at %0t: wait limit reached, seen %h expected %h", $time, 0, 1);
        complete_run();
    endtask

    // write address and data offered together, each released once taken
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw, w, b;
        b = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        for (int i = 0; i < 200 && !b; i++) begin
            @(negedge aclk);
            aw = awvalid && awready;
            w = wvalid && wready;
            b = bvalid;
            rsp = bresp;
            @(posedge aclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
            if (b) bready <= 1'b0;
        end
        if (!b) time_out();
    endtask

    task automatic axi_read(input logic [7:0] a);
        logic ar, r;
        r = 1'b0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int i = 0; i < 200 && !r; i++) begin
            @(negedge aclk);
            ar = arvalid && arready;
            r = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge aclk);
            if (ar) arvalid <= 1'b0;
            if (r) rready <= 1'b0;
        end
        if (!r) time_out();
    endtask

    // polls status until the busy flag reads as wanted
    task automatic wait_busy(input logic want);
        for (int i = 0; i < 2000; i++) begin
            axi_read(A_STAT);
            if (rd[ST_BUSY_BIT] === want) return;
        end
        time_out();
    endtask

    // waits for the card to decode character n and compares it with the oldest sent
    task automatic wait_rx(input int n);
        for (int i = 0; i < 30000 && rx_count < n; i++) @(negedge aclk);
        if (rx_count < n) time_out();
        check(rx_byte, sent.pop_front());
        check(rx_par_ok, 1'b1);
    endtask

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
        {awaddr, araddr, wdata, wstrb} <= '0;
        aresetn <= 1'b0;
        etu = 155;
        mismatches = 0;
        checks_done = 0;
        void'($urandom(28895));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(A_GUARD);
        check(rd, 32'h0000_0000);
        axi_read(A_DIV);
        check(rd, 32'h0000_0000);
        gv = 8'($urandom_range(1, 254));
        axi_write(A_GUARD, {24'h00_0000, gv}, 4'hf);
        check(32'(rsp), 32'(RESP_OKAY));
        axi_write(A_GUARD, {24'h00_0000, ~gv}, 4'h0);
        check(32'(rsp), 32'(RESP_OKAY));
        axi_read(A_GUARD);
        check(rd, {24'h00_0000, gv});
        axi_write(8'h3c, 32'h0000_00a5, 4'hf);
        check(32'(rsp), 32'(RESP_SLVERR));
        axi_read(8'h3c);
        check(rd, 32'h0000_0000);
        check(32'(rsp), 32'(RESP_SLVERR));
        $display("register test done");
        // divider 5 keeps a fifth of an etu a whole number of clocks
        axi_write(A_DIV, 32'h0000_0005, 4'hf);
        for (int protocol_select = 0; protocol_select < 2; protocol_select++) begin
            for (int prescaler_select = 0; prescaler_select < 2; prescaler_select++) begin
                for (int gsel = 0; gsel < 2; gsel++) begin
                    g = gsel ? GUARD_SPECIAL : 8'($urandom_range(0, 3));
                    etu = (prescaler_select ? 32 : 31) * 5;
                    axi_write(A_CFG2, 32'(prescaler_select), 4'hf);
                    axi_write(A_CFG1, 32'((protocol_select << PROTOCOL_SELECT_BIT) | (1 << TXMODE_BIT)), 4'hf);
                    axi_write(A_GUARD, {24'h00_0000, g}, 4'hf);
                    t0 = rx_count;
                    for (int k = 0; k < 2; k++) begin
                        sent.push_back(8'($urandom));
                        axi_write(A_HOLD, {24'h00_0000, sent[sent.size() - 1]}, 4'hf);
                        wait_busy(1'b1);
                    end
                    wait_rx(t0 + 1);
                    wait_rx(t0 + 2);
                    wait_busy(1'b0);
                    per = start_last - start_prev;
                    exp_per = etu * (10 + (protocol_select ? 1 : 2) + (gsel ? 0 : int'(g)));
                    if (gsel && REV2) exp_per = exp_per - etu / 5;
                    // a few clocks of hand-off between characters are not timing errors
                    if (per >= exp_per - 4 && per <= exp_per + 4) per = exp_per;
                    check(32'(per), 32'(exp_per));
                    check(32'(drive_len), 32'(10 * etu));
                end
            end
        end
        $display("frame test done");
        complete_run();
    end
endmodule
`default_nettype wire
